// >>> hdl/phy_port_config_next_page_rx.sv
// per-port next-page receive and port configuration registers with mdio slave
`timescale 1ns/1ps
`default_nettype none
`include "phy_cfg_defs.svh"
module phy_port_config_next_page_rx
  import phy_cfg_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [4:0] phy_addr_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  input wire logic page_rx_valid_i,
  input wire logic [15:0] page_word_i,
  input wire logic page_rx_clear_i,
  input wire logic mr_page_rx_i,
  input wire logic base_page_i,
  input wire logic link_ok_i,
  input wire logic speed_100_i,
  input wire logic full_duplex_i,
  input wire logic crs_raw_i,
  input wire logic sfd_seen_i,
  output logic page_received_o,
  output logic base_page_o,
  output logic link_pass_o,
  output logic tp_tx_enable_o,
  output logic scrambler_bypass_o,
  output logic coder_bypass_o,
  output logic jabber_enable_o,
  output logic heartbeat_enable_o,
  output logic loopback_enable_o,
  output logic crs_o,
  output logic rx_dv_o,
  output logic strip_preamble_o,
  output logic alternate_next_page_enable_o,
  output logic fiber_select_o
);

  // ****************************************
  // pin synchronisers and mdc edge
  // ****************************************
  logic mdc_s;
  logic mdio_s;
  logic mdc_d_r;
  logic mdc_rise;
  logic [4:0] phy_addr_s;
  logic [4:0] phy_addr_r;

  bit_sync #(.WIDTH(2)) u_mdio_sync (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .async_i({mdc_i, mdio_i}),
    .sync_o({mdc_s, mdio_s})
  );

  // strap path not reset: it must be live while reset is held
  bit_sync #(.WIDTH(5)) u_addr_sync (
    .mclk_i(mclk_i),
    .srst_i(1'b0),
    .ce_i(ce_i),
    .async_i(phy_addr_i),
    .sync_o(phy_addr_s)
  );

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      mdc_d_r <= 1'b0;
    else if (ce_i)
      mdc_d_r <= mdc_s;
  end

  assign mdc_rise = ce_i & mdc_s & ~mdc_d_r;

  // strap caught while reset is held, frozen afterwards
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      phy_addr_r <= phy_addr_s;
  end

  // ****************************************
  // register decode
  // ****************************************
  logic [15:0] np_rx_r;
  logic [15:0] cfg_r;

  function automatic logic reg_hit(input logic [4:0] a);
    reg_hit = (a == `NP_RX_ADDR) || (a == `CFG_ADDR) ||
              (a == `UNIMPL_A_ADDR) || (a == `UNIMPL_B_ADDR) ||
              (a == `UNIMPL_C_ADDR);
  endfunction : reg_hit

  // unimplemented addresses answer zero and swallow writes
  function automatic reg_word_t read_mux(input logic [4:0] a,
                                         input reg_word_t np,
                                         input reg_word_t cfg);
    case (a)
      `NP_RX_ADDR: read_mux = np;
      `CFG_ADDR: read_mux = cfg;
      default: read_mux = `ZERO_WORD;
    endcase
  endfunction : read_mux

  // ****************************************
  // mdio frame engine
  // ****************************************
  mdio_state_e state_r;
  logic [5:0] pre_cnt_r;
  logic [4:0] bit_cnt_r;
  logic [1:0] op_r;
  logic [9:0] addr_sr_r;
  logic [4:0] regad_r;
  logic [15:0] data_sr_r;
  logic [9:0] addr_full;
  logic cfg_wr_stb;
  logic [15:0] wdata;
  reg_word_t rd_word;

  assign rd_word = read_mux(regad_r, np_rx_r, cfg_r);
  assign addr_full = {addr_sr_r[8:0], mdio_s};
  assign wdata = {data_sr_r[14:0], mdio_s};
  assign cfg_wr_stb = mdc_rise && (state_r == MD_DATA) &&
                      (bit_cnt_r == `DATA_LAST) && (op_r == `OP_WRITE) &&
                      (regad_r == `CFG_ADDR);

  // only this port's address is answered
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      state_r <= MD_PRE;
      pre_cnt_r <= 6'h00;
      bit_cnt_r <= 5'h00;
      op_r <= 2'h0;
      addr_sr_r <= 10'h000;
      regad_r <= 5'h00;
      data_sr_r <= 16'h0000;
      mdio_o <= 1'b1;
      mdio_oe_o <= 1'b0;
    end
    else if (mdc_rise)
    begin
      case (state_r)
        MD_PRE:
        begin
          mdio_oe_o <= 1'b0;
          if (mdio_s)
          begin
            if (pre_cnt_r != `PRE_LEN)
              pre_cnt_r <= pre_cnt_r + 6'h01;
          end
          else
          begin
            if (pre_cnt_r == `PRE_LEN)
              state_r <= MD_START;
            pre_cnt_r <= 6'h00;
          end
        end
        MD_START:
        begin
          bit_cnt_r <= 5'h00;
          state_r <= mdio_s ? MD_OP : MD_PRE;
        end
        MD_OP:
        begin
          op_r <= {op_r[0], mdio_s};
          bit_cnt_r <= bit_cnt_r + 5'h01;
          if (bit_cnt_r == `OP_LAST)
          begin
            bit_cnt_r <= 5'h00;
            state_r <= MD_ADDR;
          end
        end
        MD_ADDR:
        begin
          addr_sr_r <= addr_full;
          bit_cnt_r <= bit_cnt_r + 5'h01;
          if (bit_cnt_r == `ADDR_LAST)
          begin
            bit_cnt_r <= 5'h00;
            regad_r <= addr_full[4:0];
            if ((addr_full[9:5] == phy_addr_r) && reg_hit(addr_full[4:0]) &&
                ((op_r == `OP_READ) || (op_r == `OP_WRITE)))
              state_r <= MD_TA;
            else
              state_r <= MD_PRE;
          end
        end
        MD_TA:
        begin
          bit_cnt_r <= bit_cnt_r + 5'h01;
          if (op_r == `OP_READ)
          begin
            mdio_oe_o <= 1'b1;
            mdio_o <= 1'b0;
          end
          if (bit_cnt_r == `TA_LAST)
          begin
            bit_cnt_r <= 5'h00;
            state_r <= MD_DATA;
            if (op_r == `OP_READ)
            begin
              data_sr_r <= rd_word;
              mdio_o <= rd_word[`DATA_MSB];
            end
          end
        end
        MD_DATA:
        begin
          bit_cnt_r <= bit_cnt_r + 5'h01;
          if (op_r == `OP_READ)
          begin
            data_sr_r <= {data_sr_r[14:0], 1'b0};
            mdio_o <= data_sr_r[14];
          end
          else
            data_sr_r <= wdata;
          if (bit_cnt_r == `DATA_LAST)
          begin
            bit_cnt_r <= 5'h00;
            mdio_oe_o <= 1'b0;
            mdio_o <= 1'b1;
            state_r <= MD_PRE;
          end
        end
        default:
          state_r <= MD_PRE;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // receive holder is loaded only by the negotiation engine
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      np_rx_r <= `NP_RX_RESET;
    else if (ce_i && page_rx_valid_i)
      np_rx_r <= page_word_i;
  end

  // reserved bits are not stored, so they read zero whatever is written
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      cfg_r <= `CFG_RESET;
    else if (cfg_wr_stb)
      cfg_r <= wdata & `CFG_WMASK;
  end

  // ****************************************
  // page flags
  // ****************************************
  logic page_clr;

  assign page_clr = page_rx_clear_i ||
                    (cfg_r[`CFG_ALT_NP] &&
                     (!mr_page_rx_i || cfg_r[`CFG_TX_DISABLE]));

  // a new page in the clearing cycle is kept
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      page_received_o <= 1'b0;
    else if (ce_i)
    begin
      if (page_rx_valid_i)
        page_received_o <= 1'b1;
      else if (page_clr)
        page_received_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      base_page_o <= 1'b0;
    else if (ce_i)
      base_page_o <= cfg_r[`CFG_ALT_NP] & base_page_i;
  end

  // ****************************************
  // port controls
  // ****************************************
  logic ten_mode;
  logic tx_mode;
  logic rx_dv_nxt;

  assign ten_mode = ~speed_100_i & ~cfg_r[`CFG_FIBER];
  assign tx_mode = speed_100_i & ~cfg_r[`CFG_FIBER];
  // outside 10T the delimiter alone opens the frame
  assign rx_dv_nxt = (ten_mode && cfg_r[`CFG_PRE_EN]) ? crs_raw_i : sfd_seen_i;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      link_pass_o <= 1'b0;
      tp_tx_enable_o <= 1'b0;
      scrambler_bypass_o <= 1'b0;
      coder_bypass_o <= 1'b0;
      jabber_enable_o <= 1'b1;
      heartbeat_enable_o <= 1'b0;
      loopback_enable_o <= 1'b0;
      alternate_next_page_enable_o <= 1'b0;
      fiber_select_o <= 1'b0;
    end
    else if (ce_i)
    begin
      link_pass_o <= cfg_r[`CFG_FORCE_PASS] | link_ok_i;
      tp_tx_enable_o <= ~cfg_r[`CFG_TX_DISABLE] & ~cfg_r[`CFG_FIBER];
      scrambler_bypass_o <= cfg_r[`CFG_BYP_SCRAM] & tx_mode;
      coder_bypass_o <= cfg_r[`CFG_BYP_4B5B] & tx_mode;
      jabber_enable_o <= ~(cfg_r[`CFG_JABBER_DIS] & ten_mode);
      heartbeat_enable_o <= cfg_r[`CFG_SQE_EN] & ten_mode;
      loopback_enable_o <= ten_mode & ~full_duplex_i & ~cfg_r[`CFG_LOOP_DIS];
      alternate_next_page_enable_o <= cfg_r[`CFG_ALT_NP];
      fiber_select_o <= cfg_r[`CFG_FIBER];
    end
  end

  // carrier extension uses the same-cycle data valid so both drop together
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      rx_dv_o <= 1'b0;
      crs_o <= 1'b0;
      strip_preamble_o <= 1'b0;
    end
    else if (ce_i)
    begin
      rx_dv_o <= rx_dv_nxt;
      crs_o <= crs_raw_i | (cfg_r[`CFG_CRS_SEL] & ten_mode & rx_dv_nxt);
      strip_preamble_o <= ten_mode & ~cfg_r[`CFG_PRE_EN];
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  chk_np_load: assert property (
    ce_i && page_rx_valid_i |=> np_rx_r == $past(page_word_i))
    else $error("next page word not captured");

  chk_cfg_reset: assert property (disable iff (1'b0)
    $past(srst_i) |-> (cfg_r == `CFG_RESET) && (np_rx_r == `NP_RX_RESET))
    else $error("register reset value wrong");

  chk_force_pass: assert property (
    ce_i && cfg_r[`CFG_FORCE_PASS] |=> link_pass_o)
    else $error("forced link pass not shown");

  chk_tx_off: assert property (
    ce_i && cfg_r[`CFG_TX_DISABLE] |=> !tp_tx_enable_o)
    else $error("transmitter not disabled");

  chk_scram_bypass: assert property (
    ce_i && tx_mode && cfg_r[`CFG_BYP_SCRAM] |=> scrambler_bypass_o)
    else $error("scrambler bypass missing");

  chk_jabber_off: assert property (
    ce_i && ten_mode && cfg_r[`CFG_JABBER_DIS] |=> !jabber_enable_o)
    else $error("jabber still enabled");

  chk_crs_extend: assert property (
    ce_i && ten_mode && cfg_r[`CFG_CRS_SEL] && rx_dv_nxt |=> crs_o && rx_dv_o)
    else $error("carrier not extended");

  chk_preamble_dv: assert property (
    ce_i && ten_mode && cfg_r[`CFG_PRE_EN] |=> rx_dv_o == $past(crs_raw_i))
    else $error("rx_dv not following carrier");

  chk_strip_dv: assert property (
    ce_i && ten_mode && !cfg_r[`CFG_PRE_EN] && !sfd_seen_i |=> !rx_dv_o)
    else $error("rx_dv before delimiter");

  chk_page_set: assert property (
    ce_i && page_rx_valid_i |=> page_received_o)
    else $error("page received flag lost");

  chk_unimpl_zero: assert property (
    mdc_rise && state_r == MD_TA && bit_cnt_r == `TA_LAST && op_r == `OP_READ &&
    regad_r != `NP_RX_ADDR && regad_r != `CFG_ADDR |=> data_sr_r == `ZERO_WORD)
    else $error("unimplemented register not zero");

endmodule : phy_port_config_next_page_rx
`default_nettype wire

// >>> include/phy_cfg_defs.svh
// register addresses, field positions, reset values and frame counts
`ifndef PHY_CFG_DEFS_SVH
`define PHY_CFG_DEFS_SVH

`define NP_RX_ADDR 5'h08
`define CFG_ADDR 5'h10
`define UNIMPL_A_ADDR 5'h09
`define UNIMPL_B_ADDR 5'h0A
`define UNIMPL_C_ADDR 5'h0F

`define NP_RX_RESET 16'h0000
`define CFG_RESET 16'h0080
`define CFG_WMASK 16'h7FA3
`define ZERO_WORD 16'h0000

`define CFG_FORCE_PASS 14
`define CFG_TX_DISABLE 13
`define CFG_BYP_SCRAM 12
`define CFG_BYP_4B5B 11
`define CFG_JABBER_DIS 10
`define CFG_SQE_EN 9
`define CFG_LOOP_DIS 8
`define CFG_CRS_SEL 7
`define CFG_PRE_EN 5
`define CFG_ALT_NP 1
`define CFG_FIBER 0

`define PRE_LEN 6'h20
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define OP_LAST 5'h01
`define ADDR_LAST 5'h09
`define TA_LAST 5'h01
`define DATA_LAST 5'h0F
`define DATA_MSB 15

`endif

// >>> include/phy_cfg_pkg.sv
// types shared by the port configuration block
`default_nettype none
package phy_cfg_pkg;
  typedef enum {MD_PRE, MD_START, MD_OP, MD_ADDR, MD_TA, MD_DATA} mdio_state_e;
  typedef logic [15:0] reg_word_t;
endpackage : phy_cfg_pkg
`default_nettype wire

// >>> hdl/bit_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // first stage feeds only the second stage
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else if (ce_i)
    begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule : bit_sync
`default_nettype wire

// >>> tb/mdio_station.sv
// management station model driving clause-22 frames on the mdio pin
`timescale 1ns/1ps
`default_nettype none
`include "phy_cfg_defs.svh"
module mdio_station (
  input wire logic mclk_i,
  input wire logic line_i,
  output logic mdc_o,
  output logic drv_o,
  output logic dat_o,
  output logic rd_valid_o,
  output logic [15:0] rd_data_o
);
  initial
  begin
    mdc_o = 1'b0;
    drv_o = 1'b0;
    dat_o = 1'b1;
    rd_valid_o = 1'b0;
    rd_data_o = 16'h0000;
  end
  // ********************************************
  // one bit: 10 mclk, data moves while mdc low
  // ********************************************
  task automatic bit_io(input logic b, input logic drv, output logic seen);
    @(posedge mclk_i);
    mdc_o <= 1'b0;
    drv_o <= drv;
    dat_o <= b;
    repeat (5) @(posedge mclk_i);
    // sampled before our rise: device output settled 7 mclk ago, 3 mclk after our previous rise
    seen = line_i;
    mdc_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
  endtask : bit_io
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
    input logic [15:0] wd);
    logic [13:0] hdr;
    logic [15:0] rd;
    logic s;
    logic w;
    hdr = {2'b01, op, phy, ra};
    w = (op == `OP_WRITE);
    repeat (32) bit_io(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_io(hdr[i], 1'b1, s);
    bit_io(1'b1, w, s);
    bit_io(1'b0, w, s);
    for (int i = 15; i >= 0; i--)
    begin
      bit_io(wd[i], w, s);
      rd[i] = s;
    end
    @(posedge mclk_i);
    mdc_o <= 1'b0;
    drv_o <= 1'b0;
    rd_data_o <= rd;
    rd_valid_o <= ~w;
    @(posedge mclk_i);
    rd_valid_o <= 1'b0;
  endtask : frame
endmodule : mdio_station
`default_nettype wire

// >>> tb/tb.sv
// testbench for the port configuration and next-page receive registers
`timescale 1ns/1ps
`default_nettype none
`include "phy_cfg_defs.svh"
module tb;
  import phy_cfg_pkg::*;
  localparam logic [4:0] PHY = 5'h05;
  logic mclk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1;
  logic mdc, st_drv, st_dat, rd_valid, line, m_o, m_oe;
  logic [15:0] rd_data, pw = 16'h0000;
  logic pv = 1'b0, pclr = 1'b0, mrp = 1'b0, bp = 1'b0, lk = 1'b0, spd = 1'b0, fdx = 1'b0;
  logic craw = 1'b0, sfd = 1'b0;
  logic prx, bpo, lpass, tpen, scr, cod, jab, hb, lb, crs, rxdv, strip, alt, fib;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h80A2F6F1;
  logic [31:0] r;
  logic [15:0] c;
  int err_count = 0, comparisons = 0;
  always #50 mclk_i = ~mclk_i;
  // released line is pulled up
  assign line = m_oe ? m_o : (st_drv ? st_dat : 1'b1);
  mdio_station st (.mclk_i(mclk_i), .line_i(line), .mdc_o(mdc), .drv_o(st_drv),
    .dat_o(st_dat), .rd_valid_o(rd_valid), .rd_data_o(rd_data));
  phy_port_config_next_page_rx DUT (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i),
    .phy_addr_i(PHY), .mdc_i(mdc), .mdio_i(line), .mdio_o(m_o), .mdio_oe_o(m_oe),
    .page_rx_valid_i(pv), .page_word_i(pw), .page_rx_clear_i(pclr), .mr_page_rx_i(mrp),
    .base_page_i(bp), .link_ok_i(lk), .speed_100_i(spd), .full_duplex_i(fdx),
    .crs_raw_i(craw), .sfd_seen_i(sfd), .page_received_o(prx), .base_page_o(bpo),
    .link_pass_o(lpass), .tp_tx_enable_o(tpen), .scrambler_bypass_o(scr),
    .coder_bypass_o(cod), .jabber_enable_o(jab), .heartbeat_enable_o(hb),
    .loopback_enable_o(lb), .crs_o(crs), .rx_dv_o(rxdv), .strip_preamble_o(strip),
    .alternate_next_page_enable_o(alt), .fiber_select_o(fib));
  // ********************************************
  // helpers
  // ********************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    r = seed;
  endtask : rnd
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : tick
  task automatic wr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] d);
    st.frame(`OP_WRITE, phy, ra, d);
  endtask : wr
  task automatic rd(input logic [4:0] ra, input logic [15:0] e);
    exp_q.push_back(e);
    st.frame(`OP_READ, PHY, ra, 16'h0000);
  endtask : rd
  task automatic page(input logic [15:0] w);
    @(posedge mclk_i);
    pw <= w;
    pv <= 1'b1;
    @(posedge mclk_i);
    pv <= 1'b0;
    tick(1);
  endtask : page
  task automatic rx(input logic cr, input logic sf, input logic [1:0] e);
    @(posedge mclk_i);
    craw <= cr;
    sfd <= sf;
    tick(2);
    check("crs_rx_dv", {14'h0000, crs, rxdv}, {14'h0000, e});
  endtask : rx
  // expected mode outputs; fiber or 100 mode masks the 10 mode bits
  function automatic logic [15:0] mode_exp(input logic [15:0] k, input logic s, input logic f,
    input logic l);
    logic m;
    m = ~s & ~k[0];
    return {6'h00, k[14] | l, ~k[13] & ~k[0], k[12] & s & ~k[0], k[11] & s & ~k[0],
      ~(k[10] & m), k[9] & m, m & ~f & ~k[8], m & ~k[5], k[1], k[0]};
  endfunction : mode_exp
  // read results are compared as they come back
  always @(posedge mclk_i)
  begin
    if (rd_valid === 1'b1)
      check("mdio_read", rd_data, exp_q.pop_front());
  end
  // ********************************************
  // tests
  // ********************************************
  initial
  begin
    #(100 * 40000);
    err_count++;
    $display("[ERR] watchdog expected done seen timeout");
    end_sim();
  end
  initial
  begin
    repeat (20) @(posedge mclk_i);
    srst_i <= 1'b0;
    tick(4);
    check("modes", {6'h00, lpass, tpen, scr, cod, jab, hb, lb, strip, alt, fib},
      mode_exp(`CFG_RESET, 1'b0, 1'b0, 1'b0));
    rd(`NP_RX_ADDR, `NP_RX_RESET);
    rd(`CFG_ADDR, `CFG_RESET);
    $display("test reset_values done");
    for (int i = 0; i < 4; i++)
    begin
      rnd();
      page(r[15:0]);
      check("page_flag", {15'h0000, prx}, 16'h0001);
      rd(`NP_RX_ADDR, r[15:0]);
    end
    wr(PHY, `NP_RX_ADDR, ~r[15:0]);
    rd(`NP_RX_ADDR, r[15:0]);
    foreach (c[i])
      if (i == 9 || i == 10 || i == 15)
      begin
        wr(PHY, i[4:0], 16'hFFFF);
        rd(i[4:0], `ZERO_WORD);
      end
    wr(5'h06, `CFG_ADDR, 16'h0002);
    rd(`CFG_ADDR, `CFG_RESET);
    $display("test page_and_map done");
    for (int i = 0; i < 6; i++)
    begin
      rnd();
      c = ((i == 0) ? 16'hFFFF : r[15:0]) & `CFG_WMASK;
      wr(PHY, `CFG_ADDR, c);
      spd <= r[16];
      fdx <= r[17];
      lk <= r[18];
      tick(4);
      check("modes", {6'h00, lpass, tpen, scr, cod, jab, hb, lb, strip, alt, fib},
        mode_exp(c, r[16], r[17], r[18]));
      rd(`CFG_ADDR, c & `CFG_WMASK);
    end
    $display("test config_modes done");
    wr(PHY, `CFG_ADDR, 16'h0002);
    spd <= 1'b0;
    bp <= 1'b1;
    mrp <= 1'b1;
    page(16'h1234);
    check("base_page", {15'h0000, bpo}, 16'h0001);
    @(posedge mclk_i);
    mrp <= 1'b0;
    tick(2);
    check("page_flag", {15'h0000, prx}, 16'h0000);
    wr(PHY, `CFG_ADDR, `CFG_RESET);
    tick(2);
    check("base_page", {15'h0000, bpo}, 16'h0000);
    page(16'h4321);
    tick(2);
    check("page_flag", {15'h0000, prx}, 16'h0001);
    @(posedge mclk_i);
    pclr <= 1'b1;
    @(posedge mclk_i);
    pclr <= 1'b0;
    tick(2);
    check("page_flag", {15'h0000, prx}, 16'h0000);
    $display("test page_flag done");
    rx(1'b1, 1'b0, 2'b10);
    rx(1'b1, 1'b1, 2'b11);
    rx(1'b0, 1'b1, 2'b11);
    rx(1'b0, 1'b0, 2'b00);
    wr(PHY, `CFG_ADDR, 16'h00A0);
    rx(1'b1, 1'b0, 2'b11);
    rx(1'b0, 1'b0, 2'b00);
    wr(PHY, `CFG_ADDR, 16'h0000);
    rx(1'b0, 1'b1, 2'b01);
    $display("test carrier_rx_dv done");
    tick(2);
    check("pending_reads", 16'(exp_q.size()), 16'h0000);
    end_sim();
  end
endmodule : tb
`default_nettype wire
